// ### analog_reference_scaler_pkg.sv
/*
 * Constants and types for the analog reference scaler.
 * Assumes that the parameter store presents settings as static levels.
 * Raw samples are in millivolts or microamperes.
 */
package analog_reference_scaler_pkg;

    localparam int RAW_W = 16;
    localparam int GAIN_W = 14;
    localparam int FREQ_W = 16;
    localparam int PCT_W = 32;
    localparam int PROD_W = 33;
    localparam int NUM_CH = 2;

    // Gain is held in tenths of a percent, so 1000 is a gain of 1.00.
    localparam logic [GAIN_W-1:0] GAIN_MAX = 14'h2706;
    localparam logic [GAIN_W-1:0] GAIN_FINE_LIMIT = 14'h03e8;
    localparam logic [GAIN_W-1:0] GAIN_COARSE_STEP = 14'h000a;
    localparam logic [GAIN_W-1:0] GAIN_RESET = 14'h03e8;

    localparam logic signed [7:0] OFFSET_MIN = -8'sh78;
    localparam logic signed [7:0] OFFSET_MAX = 8'sh78;
    localparam logic signed [7:0] OFFSET_RESET = 8'sh00;

    // Results are signed hundredths of a percent of full scale.
    localparam logic signed [15:0] OFFSET_TO_PCT = 16'sh0064;
    localparam logic [13:0] FULL_SCALE_PCT = 14'h2710;

    // Divisors fold range span, gain scale and percent scale together.
    localparam logic signed [PROD_W-1:0] DIV_VOLT = 33'sh0_0000_03e8;
    localparam logic signed [PROD_W-1:0] DIV_CURRENT = 33'sh0_0000_07d0;
    localparam logic signed [PROD_W-1:0] DIV_LIVE = 33'sh0_0000_0640;
    localparam logic signed [17:0] LIVE_ZERO_UA = 18'sh00fa0;

    localparam logic SIG_ZERO_BASED = 1'b0;
    localparam logic SIG_LIVE_ZERO = 1'b1;
    localparam logic [1:0] DIR_REVERSE_OK = 2'h2;

    typedef enum logic [1:0] {
        RANGE_VOLT,
        RANGE_CURRENT,
        RANGE_LIVE
    } range_t;

    typedef struct packed {
        logic [GAIN_W-1:0] gain;
        logic signed [7:0] offset;
    } scaler_cfg_t;

    typedef struct packed {
        logic [FREQ_W-1:0] freq;
        logic reverse;
    } freq_ref_t;

endpackage

// ### analog_reference_scaler.sv
/*
 * Analog input scaler that turns a sample into a frequency reference.
 * Assumes samples and settings are synchronous to mclk_in and that
 * the pot and main samples share one valid strobe.
 */
// Summary of operation
// - Signal type bit picks zero-based or live-zero.
// - Raw sample read as millivolts or microamperes.
// - Scale by gain per range, add offset.
// - Result is signed percent, feeds frequency reference.
// - Gain clamped 0 to 999, coarse steps above 99.9.
// - Offset clamped to plus or minus 120 percent.
// - Reference never below minimum frequency, zero included.
// - Negative value reverses only when permission equals two.
// - Magnitude equals fraction times maximum output frequency.
`timescale 1ns/1ps
module analog_reference_scaler (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic sample_valid_in,
    input wire logic [15:0] analog_input_one_raw_in,
    input wire logic [15:0] pot_input_raw_in,
    input wire logic input_signal_type_in,
    input wire logic input_is_current_in,
    input wire analog_reference_scaler_pkg::scaler_cfg_t main_cfg_in,
    input wire analog_reference_scaler_pkg::scaler_cfg_t pot_cfg_in,
    input wire logic ref_from_pot_in,
    input wire logic [15:0] minimum_frequency_in,
    input wire logic [15:0] maximum_output_frequency_in,
    input wire logic [1:0] direction_permission_in,
    output logic signed [31:0] scaled_input_percent_out,
    output analog_reference_scaler_pkg::freq_ref_t freq_ref_out,
    output logic ref_valid_out
);

    localparam int NCH = analog_reference_scaler_pkg::NUM_CH;
    localparam int PW = analog_reference_scaler_pkg::PROD_W;

    logic [15:0] raw [NCH];
    analog_reference_scaler_pkg::scaler_cfg_t cfg [NCH];
    analog_reference_scaler_pkg::range_t range_sel [NCH];
    logic signed [PW-1:0] prod_q [NCH];
    analog_reference_scaler_pkg::range_t range_q [NCH];
    logic signed [7:0] offset_q [NCH];
    logic signed [31:0] pct_q [NCH];
    logic valid1_q;
    logic valid2_q;

    // Above the fine range the gain moves in whole percent steps, so any
    // finer digits are dropped rather than rounded.
    function automatic logic [13:0] clamp_gain(input logic [13:0] g);
        logic [13:0] r;
        r = g;
        if (g > analog_reference_scaler_pkg::GAIN_MAX) begin
            r = analog_reference_scaler_pkg::GAIN_MAX;
        end else if (g >= analog_reference_scaler_pkg::GAIN_FINE_LIMIT) begin
            r = g - (g % analog_reference_scaler_pkg::GAIN_COARSE_STEP);
        end
        return r;
    endfunction

    function automatic logic signed [7:0] clamp_offset(
        input logic signed [7:0] o
    );
        logic signed [7:0] r;
        r = o;
        if (o > analog_reference_scaler_pkg::OFFSET_MAX) begin
            r = analog_reference_scaler_pkg::OFFSET_MAX;
        end else if (o < analog_reference_scaler_pkg::OFFSET_MIN) begin
            r = analog_reference_scaler_pkg::OFFSET_MIN;
        end
        return r;
    endfunction

    assign raw[0] = analog_input_one_raw_in;
    assign raw[1] = pot_input_raw_in;
    assign cfg[0] = main_cfg_in;
    assign cfg[1] = pot_cfg_in;

    // The panel potentiometer is a voltage divider, so it always uses
    // the zero-based voltage span.
    always_comb begin
        range_sel[1] = analog_reference_scaler_pkg::RANGE_VOLT;
        if (input_signal_type_in ==
                analog_reference_scaler_pkg::SIG_LIVE_ZERO) begin
            range_sel[0] = analog_reference_scaler_pkg::RANGE_LIVE;
        end else if (input_is_current_in) begin
            range_sel[0] = analog_reference_scaler_pkg::RANGE_CURRENT;
        end else begin
            range_sel[0] = analog_reference_scaler_pkg::RANGE_VOLT;
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_chan
            logic signed [17:0] diff;
            logic signed [14:0] gain_s;
            logic signed [PW-1:0] quot;
            logic signed [23:0] off_pct;

            always_comb begin
                if (range_sel[ch] ==
                        analog_reference_scaler_pkg::RANGE_LIVE) begin
                    diff = $signed({2'b00, raw[ch]}) -
                        analog_reference_scaler_pkg::LIVE_ZERO_UA;
                end else begin
                    diff = $signed({2'b00, raw[ch]});
                end
                gain_s = $signed({1'b0, clamp_gain(cfg[ch].gain)});
            end

            always_ff @(posedge mclk_in) begin
                if (srst_in) begin
                    prod_q[ch] <= '0;
                    range_q[ch] <= analog_reference_scaler_pkg::RANGE_VOLT;
                    offset_q[ch] <= analog_reference_scaler_pkg::OFFSET_RESET;
                end else if (sample_valid_in) begin
                    // Operands are widened first; a product kept at the
                    // operand width would wrap for a full-scale sample.
                    prod_q[ch] <= PW'(diff) * PW'(gain_s);
                    range_q[ch] <= range_sel[ch];
                    offset_q[ch] <= clamp_offset(cfg[ch].offset);
                end
            end

            // Division truncates toward zero, so both signs round alike.
            always_comb begin
                case (range_q[ch])
                    analog_reference_scaler_pkg::RANGE_VOLT: begin
                        quot = prod_q[ch] /
                            analog_reference_scaler_pkg::DIV_VOLT;
                    end
                    analog_reference_scaler_pkg::RANGE_CURRENT: begin
                        quot = prod_q[ch] /
                            analog_reference_scaler_pkg::DIV_CURRENT;
                    end
                    analog_reference_scaler_pkg::RANGE_LIVE: begin
                        quot = prod_q[ch] /
                            analog_reference_scaler_pkg::DIV_LIVE;
                    end
                    default: begin
                        quot = '0;
                    end
                endcase
                off_pct = 24'(offset_q[ch]) *
                    24'(analog_reference_scaler_pkg::OFFSET_TO_PCT);
            end

            always_ff @(posedge mclk_in) begin
                if (srst_in) begin
                    pct_q[ch] <= '0;
                end else if (valid1_q) begin
                    pct_q[ch] <= 32'(quot) + 32'(off_pct);
                end
            end
        end
    endgenerate

    // The strobe travels with the data, so back-to-back samples each get
    // their own ref_valid_out pulse three cycles later.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            valid1_q <= 1'b0;
            valid2_q <= 1'b0;
            ref_valid_out <= 1'b0;
        end else begin
            valid1_q <= sample_valid_in;
            valid2_q <= valid1_q;
            ref_valid_out <= valid2_q;
        end
    end

    // The output stage reads the pot select, the frequency limits and the
    // permission live, so they must be steady the cycle before the update.
    logic signed [31:0] pct_sel;
    logic neg;
    logic [31:0] mag_raw;
    logic [13:0] mag;
    logic [29:0] freq_prod;
    logic [15:0] freq_scaled;
    logic [15:0] freq_final;
    logic rev;

    always_comb begin
        pct_sel = ref_from_pot_in ? pct_q[1] : pct_q[0];
        neg = pct_sel[31];
        mag_raw = neg ? 32'(-pct_sel) : 32'(pct_sel);
        rev = neg &&
            (direction_permission_in ==
             analog_reference_scaler_pkg::DIR_REVERSE_OK);
        // Without reverse permission a negative value commands zero, then the minimum floor.
        if (neg && !rev) begin
            mag = '0;
        end else if (mag_raw >
                32'(analog_reference_scaler_pkg::FULL_SCALE_PCT)) begin
            // Offsets can push past full scale; never exceed the maximum.
            mag = analog_reference_scaler_pkg::FULL_SCALE_PCT;
        end else begin
            mag = mag_raw[13:0];
        end
        // Widened before the multiply so the full product is kept.
        freq_prod = 30'(mag) * 30'(maximum_output_frequency_in);
        freq_scaled = 16'(freq_prod /
            30'(analog_reference_scaler_pkg::FULL_SCALE_PCT));
        if (freq_scaled < minimum_frequency_in) begin
            freq_final = minimum_frequency_in;
        end else begin
            freq_final = freq_scaled;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            scaled_input_percent_out <= '0;
            freq_ref_out <= '0;
        end else if (valid2_q) begin
            scaled_input_percent_out <= pct_sel;
            freq_ref_out.freq <= freq_final;
            freq_ref_out.reverse <= rev;
        end
    end

endmodule

// ### scaler_properties.sv
/* Port checker for the analog reference scaler.
   Assumes it is bound to the scaler top with settings held steady. */
`timescale 1ns/1ps
module scaler_properties (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic sample_valid_in,
    input wire logic [15:0] minimum_frequency_in,
    input wire logic [15:0] maximum_output_frequency_in,
    input wire logic [1:0] direction_permission_in,
    input wire logic signed [31:0] scaled_input_percent_out,
    input wire analog_reference_scaler_pkg::freq_ref_t freq_ref_out,
    input wire logic ref_valid_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);
    // The output stage reads its settings one cycle before the update
    // shows, so settings are taken from that cycle below.
    answer_latency_a: assert property (
        sample_valid_in |-> ##3 ref_valid_out)
        else $error("update did not follow the sample");
    answer_cause_a: assert property (
        ref_valid_out |-> $past(sample_valid_in, 3))
        else $error("update without a sample");
    output_hold_a: assert property (
        !ref_valid_out |-> $stable(freq_ref_out)
        && $stable(scaled_input_percent_out))
        else $error("reference moved between updates");
    freq_floor_a: assert property (
        ref_valid_out |-> freq_ref_out.freq >= $past(minimum_frequency_in))
        else $error("reference below minimum");
    freq_ceiling_a: assert property (
        ref_valid_out |->
        freq_ref_out.freq <= $past(maximum_output_frequency_in)
        || freq_ref_out.freq == $past(minimum_frequency_in))
        else $error("reference above maximum");
    reverse_permit_a: assert property (
        ref_valid_out && freq_ref_out.reverse |->
        $past(direction_permission_in) ==
        analog_reference_scaler_pkg::DIR_REVERSE_OK)
        else $error("reverse without permission");
    reverse_sign_a: assert property (
        ref_valid_out |-> freq_ref_out.reverse ==
        (scaled_input_percent_out < 0 && $past(direction_permission_in) ==
        analog_reference_scaler_pkg::DIR_REVERSE_OK))
        else $error("reverse does not match sign");
    reset_clear_a: assert property (
        disable iff (1'b0) srst_in |=> !ref_valid_out && freq_ref_out == '0)
        else $error("outputs not cleared by reset");
endmodule

// ### motor_ref_model.sv
/* Model of the ramp logic that takes the frequency reference.
   Assumes it shares the scaler clock and reset. */
`timescale 1ns/1ps
module motor_ref_model (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire analog_reference_scaler_pkg::freq_ref_t freq_ref_in,
    input wire logic ref_valid_in,
    output analog_reference_scaler_pkg::freq_ref_t held_ref_out
);
    // The ramp only takes a new reference on the strobe, so a stray
    // change between strobes never reaches held_ref_out.
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            held_ref_out <= '0;
        end else if (ref_valid_in) begin
            held_ref_out <= freq_ref_in;
        end
    end
endmodule

// ### tb.sv
/* Self-checking bench for the analog reference scaler.
   Assumes a three cycle answer and settings held for each sample. */
`timescale 1ns/1ps
module tb;
    logic mclk_in = 1'b0, srst_in = 1'b1, sample_valid_in = 1'b0;
    logic input_signal_type_in = 1'b0, input_is_current_in = 1'b0;
    logic ref_from_pot_in = 1'b0, ref_valid_out;
    logic [15:0] analog_input_one_raw_in = '0, pot_input_raw_in = 16'h09c4;
    logic [15:0] minimum_frequency_in = '0, maximum_output_frequency_in = '0;
    logic [1:0] direction_permission_in = '0;
    analog_reference_scaler_pkg::scaler_cfg_t main_cfg_in = '0;
    analog_reference_scaler_pkg::scaler_cfg_t pot_cfg_in = {14'h07d0, 8'h0a};
    logic signed [31:0] scaled_input_percent_out;
    analog_reference_scaler_pkg::freq_ref_t freq_ref_out, held_ref;
    int bad_count = 0, n_compared = 0;
    always #10 mclk_in = ~mclk_in;
    analog_reference_scaler i_analog_reference_scaler (.mclk_in, .srst_in,
        .sample_valid_in, .analog_input_one_raw_in, .pot_input_raw_in,
        .input_signal_type_in, .input_is_current_in, .main_cfg_in,
        .pot_cfg_in, .ref_from_pot_in, .minimum_frequency_in,
        .maximum_output_frequency_in, .direction_permission_in,
        .scaled_input_percent_out, .freq_ref_out, .ref_valid_out);
    motor_ref_model i_motor_ref_model (.mclk_in, .srst_in,
        .freq_ref_in(freq_ref_out), .ref_valid_in(ref_valid_out),
        .held_ref_out(held_ref));
    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Mode packs signal type, current bit, pot select and permission.
    task automatic check_ref(input logic [15:0] raw, input logic [4:0] mode,
        input logic [21:0] cfg, input logic [15:0] fmin, fmax,
        input logic signed [31:0] e_pct, input logic [16:0] e_ref);
        int i;
        @(negedge mclk_in);
        {input_signal_type_in, input_is_current_in} = mode[4:3];
        {ref_from_pot_in, direction_permission_in} = mode[2:0];
        analog_input_one_raw_in = raw;
        main_cfg_in = cfg;
        minimum_frequency_in = fmin;
        maximum_output_frequency_in = fmax;
        sample_valid_in = 1'b1;
        @(negedge mclk_in);
        sample_valid_in = 1'b0;
        for (i = 0; i < 8 && ref_valid_out !== 1'b1; i++) @(negedge mclk_in);
        if (ref_valid_out !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: valid %h, want %h", $time,
                ref_valid_out, 1'b1);
            give_verdict();
        end
        @(negedge mclk_in);
        n_compared++;
        if (scaled_input_percent_out !== e_pct ||
            freq_ref_out !== e_ref || held_ref !== e_ref) begin
            bad_count++;
            $display("unexpected at %0t: got %h %h, want %h %h", $time,
                scaled_input_percent_out, freq_ref_out, e_pct, e_ref);
        end
    endtask
    initial begin
        repeat (3) @(negedge mclk_in);
        srst_in = 1'b0;
        check_ref(16'h1388, 5'b00010,
            {14'h03e8, 8'hba}, 16'h0000, 16'h0294,
            -32'sh7d0, {16'h0084, 1'b1});
        check_ref(16'h1388, 5'b00000,
            {14'h03e8, 8'hba}, 16'h001e, 16'h0294,
            -32'sh7d0, {16'h001e, 1'b0});
        check_ref(16'h2710, 5'b01000,
            {14'h03e8, 8'h00}, 16'h0000, 16'h0258,
            32'sh1388, {16'h012c, 1'b0});
        check_ref(16'h2ee0, 5'b10000,
            {14'h03e8, 8'h00}, 16'h0000, 16'h0258,
            32'sh1388, {16'h012c, 1'b0});
        check_ref(16'h0fa0, 5'b10000,
            {14'h03e8, 8'h00}, 16'h0032, 16'h0258,
            32'sh0, {16'h0032, 1'b0});
        check_ref(16'h0fa0, 5'b10000,
            {14'h03e8, 8'h00}, 16'h0000, 16'h0258,
            32'sh0, {16'h0000, 1'b0});
        check_ref(16'h03e8, 5'b00000,
            {14'h3fff, 8'h00}, 16'h0000, 16'h03e8,
            32'sh2706, {16'h03e7, 1'b0});
        check_ref(16'h03e8, 5'b00000,
            {14'h03ed, 8'h00}, 16'h0000, 16'h03e8,
            32'sh3e8, {16'h0064, 1'b0});
        check_ref(16'h03e8, 5'b00000,
            {14'h03e3, 8'h00}, 16'h0000, 16'h03e8,
            32'sh3e3, {16'h0063, 1'b0});
        check_ref(16'h0000, 5'b00000,
            {14'h03e8, 8'h7f}, 16'h0000, 16'h03e8,
            32'sh2ee0, {16'h03e8, 1'b0});
        check_ref(16'h0000, 5'b00010,
            {14'h03e8, 8'h80}, 16'h0000, 16'h03e8,
            -32'sh2ee0, {16'h03e8, 1'b1});
        check_ref(16'h0000, 5'b00100,
            {14'h03e8, 8'h00}, 16'h0000, 16'h03e8,
            32'sh1770, {16'h0258, 1'b0});
        give_verdict();
    end
endmodule

bind analog_reference_scaler scaler_properties i_scaler_properties (
    .mclk_in, .srst_in, .sample_valid_in, .minimum_frequency_in,
    .maximum_output_frequency_in, .direction_permission_in,
    .scaled_input_percent_out, .freq_ref_out, .ref_valid_out);
